// File: src/zdgpo_pkg.sv
package zdgpo_pkg;

  // ==========================================================================
  // Control word layout
  // ==========================================================================
  localparam int unsigned RW_BIT         = 15;
  localparam int unsigned INDEX_MSB      = 14;
  localparam int unsigned INDEX_LSB      = 8;
  localparam logic [6:0]  REG_INDEX_OSGP = 7'h0C;
  localparam int unsigned OVER_BIT       = 7;
  localparam int unsigned GP_EN_BIT      = 6;
  localparam int unsigned GP_LEVEL_LSB   = 0;
  localparam int unsigned NUM_CHAN       = 6;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;

  // ==========================================================================
  // System clock ratio codes and oversampling rates
  // ==========================================================================
  localparam logic [2:0] RATIO_128 = 3'h0;
  localparam logic [2:0] RATIO_192 = 3'h1;
  localparam logic [2:0] RATIO_256 = 3'h2;
  localparam logic [2:0] RATIO_384 = 3'h3;
  localparam logic [2:0] RATIO_512 = 3'h4;
  localparam logic [2:0] RATIO_768 = 3'h5;
  localparam logic [7:0] OSR_32X   = 8'h20;
  localparam logic [7:0] OSR_64X   = 8'h40;
  localparam logic [7:0] OSR_128X  = 8'h80;
  localparam logic [7:0] OSR_RESET = 8'h40;

  // ==========================================================================
  // Zero detection
  // ==========================================================================
  localparam int unsigned ZERO_RUN_FRAMES = 1024;
  localparam int unsigned ZERO_CNT_W      = 11;

endpackage

// File: src/zdgpo_zero_chan.sv
`timescale 1ns/1ps
module zdgpo_zero_chan #(
  parameter int unsigned RUN_FRAMES = zdgpo_pkg::ZERO_RUN_FRAMES
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // Frame events
  input  wire logic frame_tick,
  input  wire logic sample_zero,
  // Detection result
  output logic      in_zero
);

  typedef struct packed {
    logic [zdgpo_pkg::ZERO_CNT_W-1:0] count;
    logic                             flag;
  } zdgpo_chan_s;

  localparam logic [zdgpo_pkg::ZERO_CNT_W-1:0] RUN_MAX =
    zdgpo_pkg::ZERO_CNT_W'(RUN_FRAMES);

  zdgpo_chan_s st;
  zdgpo_chan_s next_st;

  // ==========================================================================
  // Zero run counter
  // ==========================================================================
  // The counter saturates so a long silence never wraps back out of the
  // zero-detect condition.
  always_comb begin
    next_st = st;
    if (frame_tick) begin
      if (!sample_zero) begin
        next_st.count = '0;
        next_st.flag  = 1'b0;
      end else if (st.count != RUN_MAX) begin
        next_st.count = st.count + 1'b1;
        next_st.flag  = (st.count == RUN_MAX - 1'b1);
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign in_zero = st.flag;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_flag_full_run: assert property (
    @(posedge clock) disable iff (reset) st.flag |-> st.count == RUN_MAX)
    else $error("zero flag set before a full run of zero frames");

  a_flag_entry: assert property (
    @(posedge clock) disable iff (reset)
    (frame_tick && sample_zero && st.count == RUN_MAX - 1'b1) |=> st.flag)
    else $error("zero flag not set at end of zero run");

  a_nonzero_restart: assert property (
    @(posedge clock) disable iff (reset)
    (frame_tick && !sample_zero) |=> !st.flag && st.count == '0)
    else $error("nonzero sample did not restart the zero run");

endmodule

// File: src/zdgpo_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Top control bit: zero write, one read.
// - High clock ratios: 64x, or 128x when set.
// - Low clock ratios: 32x, or 64x when set.
// - Enable picks zero flags or general levels.
// - Six resettable general-output level bits drive pins.
// - Zero condition after 1024 zero frames.
// - Zero condition drives channel flag active.
// - Combined flag is AND of six flags.
// - Polarity bit inverts the flag active level.
module zdgpo_top #(
  parameter int unsigned DATA_W     = 24,
  parameter int unsigned RUN_FRAMES = zdgpo_pkg::ZERO_RUN_FRAMES
) (
  // Clock and reset
  input  wire logic                                   clock,
  input  wire logic                                   reset,
  // Control word port
  input  wire logic                                   ctrl_strobe,
  input  wire logic [15:0]                            ctrl_word,
  output logic                                        rd_valid,
  output logic [15:0]                                 rd_data,
  // Configuration from neighbouring logic
  input  wire logic [2:0]                             sysclk_ratio,
  input  wire logic                                   zero_polarity_invert,
  output logic [7:0]                                  oversample_rate,
  // Audio frame
  input  wire logic                                   frame_clock,
  input  wire logic [zdgpo_pkg::NUM_CHAN*DATA_W-1:0]  chan_data,
  // Flag and general-purpose pins
  output logic [zdgpo_pkg::NUM_CHAN-1:0]              chan_zero_flag,
  output logic                                        all_zero_flag
);

  localparam int unsigned NC = zdgpo_pkg::NUM_CHAN;

  typedef struct packed {
    logic [7:0]    ctrl;
    logic [2:0]    fsync;
    logic [NC-1:0] pins;
    logic          all_zero;
    logic          rd_valid;
    logic [15:0]   rd_data;
    logic [7:0]    osr;
  } zdgpo_top_s;

  zdgpo_top_s    st;
  zdgpo_top_s    next_st;
  logic          frame_tick;
  logic [NC-1:0] chan_zero;
  logic [NC-1:0] sample_zero;
  logic          hit;
  logic          gp_out_enable;
  logic [NC-1:0] gp_out_level;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic ratio_is_low(input logic [2:0] r);
    ratio_is_low = (r == zdgpo_pkg::RATIO_128) ||
                   (r == zdgpo_pkg::RATIO_192);
  endfunction

  // Unlisted ratio codes are treated like the high group so the rate is
  // never undefined.
  function automatic logic [7:0] osr_of(input logic [2:0] r,
                                        input logic       over);
    if (ratio_is_low(r)) begin
      osr_of = over ? zdgpo_pkg::OSR_64X : zdgpo_pkg::OSR_32X;
    end else begin
      osr_of = over ? zdgpo_pkg::OSR_128X : zdgpo_pkg::OSR_64X;
    end
  endfunction

  assign hit = ctrl_strobe &&
    (ctrl_word[zdgpo_pkg::INDEX_MSB:zdgpo_pkg::INDEX_LSB] ==
     zdgpo_pkg::REG_INDEX_OSGP);
  assign frame_tick    = st.fsync[1] && !st.fsync[2];
  assign gp_out_enable = st.ctrl[zdgpo_pkg::GP_EN_BIT];
  assign gp_out_level  = st.ctrl[zdgpo_pkg::GP_LEVEL_LSB +: NC];

  // ==========================================================================
  // Per-channel zero detectors
  // ==========================================================================
  genvar g;
  generate
    for (g = 0; g < NC; g++) begin : g_chan
      assign sample_zero[g] = (chan_data[g*DATA_W +: DATA_W] == '0);
      zdgpo_zero_chan #(
        .RUN_FRAMES (RUN_FRAMES)
      ) u_zero (
        .clock       (clock),
        .reset       (reset),
        .frame_tick  (frame_tick),
        .sample_zero (sample_zero[g]),
        .in_zero     (chan_zero[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Register, pin and rate logic
  // ==========================================================================
  // The frame clock is a pin, so it is synchronised before the edge detect;
  // channel data must be stable around the sampled edge.
  always_comb begin
    next_st          = st;
    next_st.fsync    = {st.fsync[1:0], frame_clock};
    next_st.rd_valid = 1'b0;
    if (hit && !ctrl_word[zdgpo_pkg::RW_BIT]) begin
      next_st.ctrl = ctrl_word[7:0];
    end
    if (hit && ctrl_word[zdgpo_pkg::RW_BIT]) begin
      next_st.rd_valid = 1'b1;
      next_st.rd_data  = {1'b0, zdgpo_pkg::REG_INDEX_OSGP, st.ctrl};
    end
    next_st.osr = osr_of(sysclk_ratio,
                         st.ctrl[zdgpo_pkg::OVER_BIT]);
    if (gp_out_enable) begin
      next_st.pins = gp_out_level;
    end else begin
      next_st.pins = chan_zero ^ {NC{zero_polarity_invert}};
    end
    next_st.all_zero = (&chan_zero) ^ zero_polarity_invert;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st          <= '0;
      st.ctrl     <= zdgpo_pkg::CTRL_RESET;
      st.osr      <= zdgpo_pkg::OSR_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign rd_valid        = st.rd_valid;
  assign rd_data         = st.rd_data;
  assign oversample_rate = st.osr;
  assign chan_zero_flag  = st.pins;
  assign all_zero_flag   = st.all_zero;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_write_stores: assert property (
    @(posedge clock) disable iff (reset)
    (hit && !ctrl_word[15]) |=> st.ctrl == $past(ctrl_word[7:0]))
    else $error("register write not stored");

  a_read_returns: assert property (
    @(posedge clock) disable iff (reset)
    (hit && ctrl_word[15]) |=> rd_valid && rd_data[7:0] == $past(st.ctrl))
    else $error("register read did not return contents");

  a_write_no_read: assert property (
    @(posedge clock) disable iff (reset)
    !(ctrl_strobe && ctrl_word[15]) |=> !rd_valid)
    else $error("read answer without a read request");

  a_rate_high: assert property (
    @(posedge clock) disable iff (reset)
    !ratio_is_low(sysclk_ratio) |=>
      oversample_rate == ($past(st.ctrl[7]) ? 8'h80 : 8'h40))
    else $error("wrong oversampling for high clock ratio");

  a_rate_low: assert property (
    @(posedge clock) disable iff (reset)
    ratio_is_low(sysclk_ratio) |=>
      oversample_rate == ($past(st.ctrl[7]) ? 8'h40 : 8'h20))
    else $error("wrong oversampling for low clock ratio");

  a_gp_pins: assert property (
    @(posedge clock) disable iff (reset)
    gp_out_enable |=> chan_zero_flag == $past(gp_out_level))
    else $error("general outputs not on the pins");

  a_flag_pins: assert property (
    @(posedge clock) disable iff (reset)
    !gp_out_enable |=>
      chan_zero_flag ==
        ($past(chan_zero) ^ {NC{$past(zero_polarity_invert)}}))
    else $error("zero flags not on the pins");

  a_all_zero: assert property (
    @(posedge clock) disable iff (reset)
    1'b1 |=> all_zero_flag ==
      ((&$past(chan_zero)) ^ $past(zero_polarity_invert)))
    else $error("combined flag is not the AND of flags");

  a_nonzero_clears: assert property (
    @(posedge clock) disable iff (reset)
    (frame_tick && !(&sample_zero)) |=> ##1
      all_zero_flag == zero_polarity_invert)
    else $error("nonzero sample did not clear the combined flag");

  // A refused index must leave no trace, since the port is shared with the
  // neighbouring registers.
  a_index_refused: assert property (
    @(posedge clock) disable iff (reset)
    (ctrl_strobe && !hit) |=> st.ctrl == $past(st.ctrl) && !rd_valid)
    else $error("access to another index was taken");

  a_read_keeps: assert property (
    @(posedge clock) disable iff (reset)
    (hit && ctrl_word[15]) |=> st.ctrl == $past(st.ctrl))
    else $error("register read changed the contents");

  a_tick_single: assert property (
    @(posedge clock) disable iff (reset)
    frame_tick |=> !frame_tick)
    else $error("one frame edge counted twice");

  a_rate_legal: assert property (
    @(posedge clock) disable iff (reset)
    oversample_rate == zdgpo_pkg::OSR_32X ||
    oversample_rate == zdgpo_pkg::OSR_64X ||
    oversample_rate == zdgpo_pkg::OSR_128X)
    else $error("oversampling rate outside the three settings");

  c_write:    cover property (@(posedge clock) hit && !ctrl_word[15]);
  c_read:     cover property (@(posedge clock) rd_valid);
  c_all_zero: cover property (@(posedge clock) &chan_zero);
  c_gp_mode:  cover property (@(posedge clock) gp_out_enable && |gp_out_level);
  c_invert:   cover property (@(posedge clock)
                zero_polarity_invert && (&chan_zero));

endmodule

// File: dv/zdgpo_host_model.sv
`timescale 1ns/1ps
// ============================================================================
// Host side of the control word port
// ============================================================================
module zdgpo_host_model (
  // Clock
  input  wire logic        clock,
  // Control word port
  output logic             ctrl_strobe,
  output logic [15:0]      ctrl_word,
  input  wire logic        rd_valid,
  input  wire logic [15:0] rd_data
);
  initial begin
    ctrl_strobe = 1'b0;
    ctrl_word   = 16'h0000;
  end

  // One word per access, strobed for exactly one rising edge.
  task automatic access(input logic rd, input logic [6:0] idx,
                        input logic [7:0] data, output logic [15:0] got,
                        output logic seen);
    @(negedge clock);
    ctrl_strobe = 1'b1;
    ctrl_word   = {rd, idx, data};
    @(negedge clock);
    ctrl_strobe = 1'b0;
    // A released word is scrambled so stale bits cannot pass for a request.
    ctrl_word   = ~ctrl_word;
    seen        = (rd_valid === 1'b1);
    got         = rd_data;
  endtask
endmodule

// File: dv/zdgpo_top_test.sv
`timescale 1ns/1ps
// ============================================================================
// Self-checking bench
// ============================================================================
module zdgpo_top_test;
  localparam int unsigned RUN = 4;
  localparam int unsigned W   = 24;
  logic          clock = 1'b0;
  logic          reset = 1'b1;
  logic          ctrl_strobe;
  logic [15:0]   ctrl_word;
  logic          rd_valid;
  logic [15:0]   rd_data;
  logic [2:0]    sysclk_ratio = 3'h2;
  logic          zero_polarity_invert = 1'b0;
  logic [7:0]    oversample_rate;
  logic          frame_clock = 1'b0;
  logic [6*W-1:0] chan_data = {6{24'h000001}};
  logic [5:0]    chan_zero_flag;
  logic          all_zero_flag;
  logic [15:0]   got;
  logic          seen;
  logic [7:0]    exp_rate;
  int            fails = 0;
  int            checks = 0;
  int            cycles = 0;

  always #12.5 clock = ~clock;

  zdgpo_top #(.DATA_W(W), .RUN_FRAMES(RUN)) i_zdgpo_top (
    .clock(clock), .reset(reset), .ctrl_strobe(ctrl_strobe),
    .ctrl_word(ctrl_word), .rd_valid(rd_valid), .rd_data(rd_data),
    .sysclk_ratio(sysclk_ratio),
    .zero_polarity_invert(zero_polarity_invert),
    .oversample_rate(oversample_rate), .frame_clock(frame_clock),
    .chan_data(chan_data), .chan_zero_flag(chan_zero_flag),
    .all_zero_flag(all_zero_flag));

  zdgpo_host_model i_zdgpo_host_model (
    .clock(clock), .ctrl_strobe(ctrl_strobe), .ctrl_word(ctrl_word),
    .rd_valid(rd_valid), .rd_data(rd_data));

  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] exp, input logic [15:0] act);
    checks++;
    if (act !== exp) begin
      fails++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    i_zdgpo_host_model.access(1'b0, idx, d, got, seen);
    repeat (3) @(negedge clock);
  endtask

  task automatic rd(input logic [6:0] idx);
    i_zdgpo_host_model.access(1'b1, idx, 8'h00, got, seen);
  endtask

  // Frame pulses are slow against the clock, then the pipeline settles.
  task automatic frames(input int n);
    repeat (n) begin
      @(negedge clock) frame_clock = 1'b1;
      repeat (4) @(negedge clock);
      frame_clock = 1'b0;
      repeat (4) @(negedge clock);
    end
    repeat (6) @(negedge clock);
  endtask

  function automatic logic [15:0] pins();
    return {9'h000, all_zero_flag, chan_zero_flag};
  endfunction

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    repeat (10) @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    rd(7'h0C);
    check(16'h0C00, got);
    check(16'h0001, {15'h0000, seen});
    check(16'h0040, {8'h00, oversample_rate});
    check(16'h0000, pins());
    $display("test reset done");
    for (int r = 0; r < 6; r++) begin
      for (int o = 0; o < 2; o++) begin
        sysclk_ratio = r[2:0];
        // Low ratios take the rate bit as a high-rate host would.
        wr(7'h0C, {o[0], 7'h00});
        exp_rate = (r < 2) ? (o ? 8'h40 : 8'h20) : (o ? 8'h80 : 8'h40);
        check({8'h00, exp_rate}, {8'h00, oversample_rate});
      end
    end
    wr(7'h0C, 8'h00);
    $display("test rate done");
    wr(7'h0B, 8'hFF);
    rd(7'h0C);
    check(16'h0C00, got);
    rd(7'h0B);
    check(16'h0000, {15'h0000, seen});
    $display("test index done");
    chan_data = '0;
    frames(RUN - 1);
    check(16'h0000, pins());
    frames(1);
    check(16'h007F, pins());
    chan_data[2*W+:W] = 24'h000001;
    frames(1);
    check(16'h003B, pins());
    chan_data = '0;
    frames(RUN - 1);
    check(16'h003B, pins());
    frames(1);
    check(16'h007F, pins());
    $display("test zero done");
    zero_polarity_invert = 1'b1;
    repeat (3) @(negedge clock);
    check(16'h0000, pins());
    zero_polarity_invert = 1'b0;
    repeat (3) @(negedge clock);
    $display("test polarity done");
    wr(7'h0C, 8'h6A);
    check(16'h002A, {10'h000, chan_zero_flag});
    rd(7'h0C);
    check(16'h0C6A, got);
    wr(7'h0C, 8'h55);
    check(16'h0015, {10'h000, chan_zero_flag});
    wr(7'h0C, 8'h15);
    check(16'h003F, {10'h000, chan_zero_flag});
    $display("test gpo done");
    test_done();
  end
endmodule
